// ### design/bip_edge_irq.sv
// edge interrupt detector for the interrupt-capable port
`timescale 1ns/1ns
module bip_edge_irq (
  input  wire logic     i_clk,
  input  wire logic     i_rst_n,
  input  wire logic     i_ce,
  bip_irq_if.det        irq
);
  import bip_pkg::*;

  typedef struct packed {
    logic [3:0] prev;
    logic       irq_a;
    logic       irq_b;
  } bip_edge_state_type;

  bip_edge_state_type state_q;
  bip_edge_state_type state_d;

  function automatic logic pin_edge(input logic [1:0] code, input logic now, input logic was);
    logic hit;
    hit = 1'b0;
    case (bip_pin_mode_type'(code))
      PIN_IN_RISE: hit = now & ~was;
      PIN_IN_FALL: hit = ~now & was;
      default:     hit = 1'b0;
    endcase
    return hit;
  endfunction

  always_comb begin
    logic [3:0] edges;
    edges   = 4'h0;
    state_d = state_q;
    if (i_ce) begin
      for (int i = 0; i < NIB_WIDTH; i++) begin
        edges[i] = pin_edge(irq.mode[PC_CODE_WIDTH*i +: PC_CODE_WIDTH],
                            irq.pin_lvl[i], state_q.prev[i]);
      end
      state_d.prev  = irq.pin_lvl;
      // pins 0/1 share one request line, pins 2/3 the other
      state_d.irq_a = |edges[1:0];
      state_d.irq_b = |edges[3:2];
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= '{prev: PC_DATA_RST, irq_a: 1'b0, irq_b: 1'b0};
    end else begin
      state_q <= state_d;
    end
  end

  assign irq.irq_a = state_q.irq_a;
  assign irq.irq_b = state_q.irq_b;

endmodule // bip_edge_irq

// ### design/bip_irq_if.sv
// carrier between the port block and its edge interrupt detector
`timescale 1ns/1ns
interface bip_irq_if;
  logic [3:0] pin_lvl;
  logic [7:0] mode;
  logic       irq_a;
  logic       irq_b;

  modport src (output pin_lvl, output mode, input irq_a, input irq_b);
  modport det (input pin_lvl, input mode, output irq_a, output irq_b);
endinterface

// ### design/bip_pkg.sv
// shared constants and types of the bidirectional i/o port block
package bip_pkg;

  typedef logic [3:0] bip_nibble_type;

  // primary (data) and auxiliary (control) share these addresses; port a has a primary register only
  localparam logic [3:0] ADDR_PORT_A = 4'h1;
  localparam logic [3:0] ADDR_PORT_B = 4'h2;
  localparam logic [3:0] ADDR_PORT_C = 4'h5;

  // port a carries nibble bits 0 and 3 only
  localparam int PA_WIDTH  = 2;
  localparam int PA_BIT_LO = 0;
  localparam int PA_BIT_HI = 3;
  localparam int NIB_WIDTH = 4;
  localparam int PC_CTRL_WIDTH = 8;
  localparam int PC_CODE_WIDTH = 2;

  // reset values
  localparam logic [1:0] PA_LATCH_RST = 2'h3;
  localparam logic [3:0] PB_DATA_RST  = 4'hf;
  localparam logic [3:0] PB_DIR_RST   = 4'hf;
  localparam logic [3:0] PC_DATA_RST  = 4'hf;
  localparam logic [7:0] PC_CTRL_RST  = 8'hff;
  localparam logic [3:0] NIB_ZERO     = 4'h0;

  // two-bit pin code of port c: bit 1 is the high mode bit, bit 0 the low
  typedef enum logic [1:0] {
    PIN_OUT      = 2'b00,
    PIN_IN_RISE  = 2'b01,
    PIN_IN_FALL  = 2'b10,
    PIN_IN_QUIET = 2'b11
  } bip_pin_mode_type;

  // which nibble of the byte-wide control register comes next
  typedef enum logic {
    NIB_LO = 1'b0,
    NIB_HI = 1'b1
  } bip_nib_type;

endpackage

// ### design/bip_ports.sv
// bidirectional i/o ports: auto-direction, per-bit direction and interrupt-capable port
// Summary of operation
// - four-bit ports carry four bits; two-bit port carries nibble bits 0 and 3
// - data register at primary address, control register at auxiliary same address
// - auto-direction port: output instruction selects output, input instruction input
// - output instruction stores data in latches and drives pins right after
// - after reset auto-direction latches are all ones and port is input
// - input instruction on auto-direction port returns pin levels, not latches
// - per-bit direction port: control bit one is input, zero is output
// - per-bit direction port data and control reset to all ones
// - reading per-bit port data returns pin levels even for outputs
// - during reset bit 0 of per-bit port gets strong pull-up
// - during reset bit 0 of per-bit port has its pull-down switched off
// - interrupt port pins feed two requests, each maskable, rising or falling
// - interrupt port control register holds interrupt and direction per pin
// - byte control register loaded by two writes, low nibble first
// - pin code: 11 quiet input, 01 rising, 10 falling, 00 output
// - first write configures pins 0 and 1, second pins 2 and 3
`timescale 1ns/1ns
module bip_ports (
  input  wire logic                       I_CORE_CLK,
  input  wire logic                       I_RST_N,
  input  wire logic                       I_CE,
  // core i/o instruction port
  input  wire logic [3:0]                 I_IO_ADDR,
  input  wire logic                       I_IO_AUX,
  input  wire logic                       I_IO_WR,
  input  wire logic                       I_IO_RD,
  input  wire bip_pkg::bip_nibble_type    I_IO_WDATA,
  output            bip_pkg::bip_nibble_type O_IO_RDATA,
  output logic                            O_IO_RVALID,
  // port a: auto-direction, index 0 is nibble bit 0, index 1 is nibble bit 3
  input  wire logic [1:0]                 I_PA_PIN,
  output logic      [1:0]                 O_PA_OUT,
  output logic      [1:0]                 O_PA_OE,
  // port b: per-bit direction
  input  wire bip_pkg::bip_nibble_type    I_PB_PIN,
  output            bip_pkg::bip_nibble_type O_PB_OUT,
  output            bip_pkg::bip_nibble_type O_PB_OE,
  output logic                            O_PB0_STRONG_PU,
  output logic                            O_PB0_PULLDOWN_EN,
  // port c: per-bit direction with edge interrupts
  input  wire bip_pkg::bip_nibble_type    I_PC_PIN,
  output            bip_pkg::bip_nibble_type O_PC_OUT,
  output            bip_pkg::bip_nibble_type O_PC_OE,
  output logic                            O_IRQ_A,
  output logic                            O_IRQ_B
);
  import bip_pkg::*;

  typedef struct packed {
    logic [1:0]     pa_sync1;
    logic [1:0]     pa_sync2;
    bip_nibble_type pb_sync1;
    bip_nibble_type pb_sync2;
    bip_nibble_type pc_sync1;
    bip_nibble_type pc_sync2;
    logic [1:0]     pa_latch;
    logic [1:0]     pa_oe;
    bip_nibble_type pb_data;
    bip_nibble_type pb_dir;
    bip_nibble_type pb_oe;
    bip_nibble_type pc_data;
    logic [7:0]     pc_ctrl;
    bip_nibble_type pc_oe;
    bip_nib_type    nib;
    bip_nibble_type rdata;
    logic           rvalid;
    logic           pb0_strong_pu;
    logic           pb0_pd_en;
    logic [2:0]     warm;
  } bip_state_type;

  // edge detection stays masked until the pin synchronisers hold real samples
  localparam logic [2:0] WARM_RST = 3'h0;

  localparam bip_state_type STATE_RST = '{
    pa_sync1:      PA_LATCH_RST,
    pa_sync2:      PA_LATCH_RST,
    pb_sync1:      PB_DATA_RST,
    pb_sync2:      PB_DATA_RST,
    pc_sync1:      PC_DATA_RST,
    pc_sync2:      PC_DATA_RST,
    pa_latch:      PA_LATCH_RST,
    pa_oe:         2'h0,
    pb_data:       PB_DATA_RST,
    pb_dir:        PB_DIR_RST,
    pb_oe:         NIB_ZERO,
    pc_data:       PC_DATA_RST,
    pc_ctrl:       PC_CTRL_RST,
    pc_oe:         NIB_ZERO,
    nib:           NIB_LO,
    rdata:         NIB_ZERO,
    rvalid:        1'b0,
    pb0_strong_pu: 1'b1,
    pb0_pd_en:     1'b0,
    warm:          WARM_RST
  };

  logic          rst_sync1_q;
  logic          rst_sync2_q;
  bip_state_type state_q;
  bip_state_type state_d;

  bip_irq_if irq_bus ();

  // an instruction hits a register when address and primary/auxiliary select match
  function automatic logic reg_hit(input logic [3:0] addr, input logic aux,
                                   input logic [3:0] want, input logic want_aux);
    return (addr == want) && (aux == want_aux);
  endfunction

  // a port c pin drives only with code 00
  function automatic bip_nibble_type pc_drive(input logic [7:0] ctrl);
    bip_nibble_type oe;
    oe = NIB_ZERO;
    for (int i = 0; i < NIB_WIDTH; i++) begin
      oe[i] = (bip_pin_mode_type'(ctrl[PC_CODE_WIDTH*i +: PC_CODE_WIDTH]) == PIN_OUT);
    end
    return oe;
  endfunction

  // spread the two port a bits onto their nibble positions
  function automatic bip_nibble_type pa_to_nibble(input logic [1:0] pa);
    bip_nibble_type nib;
    nib = NIB_ZERO;
    nib[PA_BIT_LO] = pa[0];
    nib[PA_BIT_HI] = pa[1];
    return nib;
  endfunction

  // reset release through two flops; assertion still acts at once
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_sync1_q <= 1'b0;
      rst_sync2_q <= 1'b0;
    end else begin
      rst_sync1_q <= 1'b1;
      rst_sync2_q <= rst_sync1_q;
    end
  end

  always_comb begin
    logic wr_pa;
    logic rd_pa;
    logic wr_pb_dat;
    logic wr_pb_ctl;
    logic wr_pc_dat;
    logic wr_pc_ctl;
    logic rd_pb;
    logic rd_pc;
    wr_pa     = 1'b0;
    rd_pa     = 1'b0;
    wr_pb_dat = 1'b0;
    wr_pb_ctl = 1'b0;
    wr_pc_dat = 1'b0;
    wr_pc_ctl = 1'b0;
    rd_pb     = 1'b0;
    rd_pc     = 1'b0;
    state_d   = state_q;

    if (I_CE) begin
      // pin synchronisers; only the second stage is read below
      state_d.pa_sync1 = I_PA_PIN;
      state_d.pa_sync2 = state_q.pa_sync1;
      state_d.pb_sync1 = I_PB_PIN;
      state_d.pb_sync2 = state_q.pb_sync1;
      state_d.pc_sync1 = I_PC_PIN;
      state_d.pc_sync2 = state_q.pc_sync1;
      state_d.warm     = {state_q.warm[1:0], 1'b1};

      // reset-only pad controls fall back once reset is over
      state_d.pb0_strong_pu = 1'b0;
      state_d.pb0_pd_en     = 1'b1;

      // address decode
      if (reg_hit(I_IO_ADDR, I_IO_AUX, ADDR_PORT_A, 1'b0)) begin
        wr_pa = I_IO_WR;
        rd_pa = I_IO_RD;
      end else if (reg_hit(I_IO_ADDR, I_IO_AUX, ADDR_PORT_B, 1'b0)) begin
        wr_pb_dat = I_IO_WR;
        rd_pb     = I_IO_RD;
      end else if (reg_hit(I_IO_ADDR, I_IO_AUX, ADDR_PORT_B, 1'b1)) begin
        wr_pb_ctl = I_IO_WR;
      end else if (reg_hit(I_IO_ADDR, I_IO_AUX, ADDR_PORT_C, 1'b0)) begin
        wr_pc_dat = I_IO_WR;
        rd_pc     = I_IO_RD;
      end else if (reg_hit(I_IO_ADDR, I_IO_AUX, ADDR_PORT_C, 1'b1)) begin
        wr_pc_ctl = I_IO_WR;
      end

      // port a: direction follows the last instruction, whole port at once
      if (wr_pa) begin
        state_d.pa_latch = {I_IO_WDATA[PA_BIT_HI], I_IO_WDATA[PA_BIT_LO]};
        state_d.pa_oe    = 2'h3;
      end else if (rd_pa) begin
        state_d.pa_oe = 2'h0;
      end

      // port b
      if (wr_pb_dat) begin
        state_d.pb_data = I_IO_WDATA;
      end
      if (wr_pb_ctl) begin
        state_d.pb_dir = I_IO_WDATA;
        state_d.pb_oe  = ~I_IO_WDATA;
      end

      // port c
      if (wr_pc_dat) begin
        state_d.pc_data = I_IO_WDATA;
      end
      if (wr_pc_ctl) begin
        case (state_q.nib)
          NIB_LO: begin
            state_d.pc_ctrl[NIB_WIDTH-1:0] = I_IO_WDATA;
            state_d.nib                    = NIB_HI;
          end
          NIB_HI: begin
            state_d.pc_ctrl[PC_CTRL_WIDTH-1:NIB_WIDTH] = I_IO_WDATA;
            state_d.nib                                = NIB_LO;
          end
          default: begin
            state_d.nib = NIB_LO;
          end
        endcase
      end
      // one code per pin sets both direction and interrupt mode
      state_d.pc_oe = pc_drive(state_d.pc_ctrl);

      // data reads show synchronised pin levels, other reads return zero; control registers are write-only
      state_d.rvalid = I_IO_RD;
      if (rd_pa) begin
        state_d.rdata = pa_to_nibble(state_q.pa_sync2);
      end else if (rd_pb) begin
        state_d.rdata = state_q.pb_sync2;
      end else if (rd_pc) begin
        state_d.rdata = state_q.pc_sync2;
      end else if (I_IO_RD) begin
        state_d.rdata = NIB_ZERO;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge rst_sync2_q) begin
    if (!rst_sync2_q) begin
      state_q <= STATE_RST;
    end else begin
      state_q <= state_d;
    end
  end

  // edge detection sees the synchronised pins and the live control codes
  assign irq_bus.pin_lvl = state_q.pc_sync2;
  // the stale reset level of the chain would otherwise look like an edge after reset
  assign irq_bus.mode    = state_q.warm[2] ? state_q.pc_ctrl : PC_CTRL_RST;

  bip_edge_irq u_edge_irq (
    .i_clk   (I_CORE_CLK),
    .i_rst_n (rst_sync2_q),
    .i_ce    (I_CE),
    .irq     (irq_bus.det)
  );

  assign O_IO_RDATA        = state_q.rdata;
  assign O_IO_RVALID       = state_q.rvalid;
  assign O_PA_OUT          = state_q.pa_latch;
  assign O_PA_OE           = state_q.pa_oe;
  assign O_PB_OUT          = state_q.pb_data;
  assign O_PB_OE           = state_q.pb_oe;
  assign O_PB0_STRONG_PU   = state_q.pb0_strong_pu;
  assign O_PB0_PULLDOWN_EN = state_q.pb0_pd_en;
  assign O_PC_OUT          = state_q.pc_data;
  assign O_PC_OE           = state_q.pc_oe;
  assign O_IRQ_A           = irq_bus.irq_a;
  assign O_IRQ_B           = irq_bus.irq_b;

endmodule // bip_ports

// ### test/bip_pin_model.sv
// external pull network and loads on the port pins, a=9:8 b=7:4 c=3:0
`timescale 1ns/1ns
module bip_pin_model (
  input  wire logic [9:0] i_out,
  input  wire logic [9:0] i_oe,
  input  wire logic [9:0] i_pull,
  input  wire logic       i_pb0_pu,
  output logic      [9:0] o_pin
);
  // a released pin settles to its pull level, never to a stale driven value
  always_comb begin
    o_pin = (i_oe & i_out) | (~i_oe & i_pull);
    // strong internal pull-up overrides a weak external pull-down
    if (i_pb0_pu) o_pin[4] = 1'b1;
  end
endmodule // bip_pin_model

// ### test/bip_ports_checker.sv
// concurrent checks on the ports of the bidirectional i/o port block
`timescale 1ns/1ns
module bip_ports_checker (
  input wire logic       I_CORE_CLK,
  input wire logic       I_RST_N,
  input wire logic       I_CE,
  input wire logic [3:0] I_IO_ADDR,
  input wire logic       I_IO_AUX,
  input wire logic       I_IO_WR,
  input wire logic       I_IO_RD,
  input wire logic [3:0] I_IO_WDATA,
  input wire logic       O_IO_RVALID,
  input wire logic [1:0] O_PA_OUT,
  input wire logic [1:0] O_PA_OE,
  input wire logic [3:0] O_PB_OE,
  input wire logic       O_PB0_STRONG_PU,
  input wire logic       O_PB0_PULLDOWN_EN,
  input wire logic [3:0] I_PC_PIN,
  input wire logic [3:0] O_PC_OE,
  input wire logic       O_IRQ_A
);
  import bip_pkg::*;
  // shadow of the byte-wide control register and its nibble order
  logic [7:0] ctl_q;
  logic       nib_q;
  logic       ctl_wr;
  assign ctl_wr = I_CE && I_IO_WR && I_IO_AUX && I_IO_ADDR == ADDR_PORT_C;
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ctl_q <= PC_CTRL_RST;
      nib_q <= 1'b0;
    end else if (ctl_wr) begin
      ctl_q <= nib_q ? {I_IO_WDATA, ctl_q[3:0]} : {ctl_q[7:4], I_IO_WDATA};
      nib_q <= ~nib_q;
    end
  end
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_wr(logic [3:0] a, logic x);
    I_CE && I_IO_WR && I_IO_ADDR == a && I_IO_AUX == x;
  endsequence
  sequence s_rise_a;
    I_CE && $rose(I_PC_PIN[0]) && ctl_q[1:0] == 2'b01;
  endsequence
  property p_rvalid; I_CE |=> O_IO_RVALID == $past(I_IO_RD); endproperty
  property p_pa_wr;
    s_wr(ADDR_PORT_A, 1'b0) |=> O_PA_OE == 2'b11 && O_PA_OUT[1] == $past(I_IO_WDATA[3])
      && O_PA_OUT[0] == $past(I_IO_WDATA[0]);
  endproperty
  property p_pb_dir; s_wr(ADDR_PORT_B, 1'b1) |=> O_PB_OE == ~$past(I_IO_WDATA); endproperty
  property p_pc_oe;
    O_PC_OE == {ctl_q[7:6] == 2'b00, ctl_q[5:4] == 2'b00, ctl_q[3:2] == 2'b00,
      ctl_q[1:0] == 2'b00};
  endproperty
  property p_pb0_rel;
    $rose(I_RST_N) |-> ##[1:4] (!O_PB0_STRONG_PU && O_PB0_PULLDOWN_EN);
  endproperty
  property p_irq_rise; s_rise_a |-> ##[1:6] O_IRQ_A; endproperty
  property p_irq_mask; O_IRQ_A |-> $past(ctl_q[3:0]) != 4'hf; endproperty
  property p_irq_pulse; O_IRQ_A && I_CE |=> !O_IRQ_A; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid wrong");
  a_pa_wr: assert property (p_pa_wr) else $error("port a write");
  a_pb_dir: assert property (p_pb_dir) else $error("port b direction");
  a_pc_oe: assert property (p_pc_oe) else $error("port c enables");
  a_pb0_rel: assert property (p_pb0_rel) else $error("pin0 pulls");
  a_irq_rise: assert property (p_irq_rise) else $error("rise missed");
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq too wide");
endmodule // bip_ports_checker

bind bip_ports bip_ports_checker u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_CE(I_CE), .I_IO_ADDR(I_IO_ADDR),
  .I_IO_AUX(I_IO_AUX), .I_IO_WR(I_IO_WR), .I_IO_RD(I_IO_RD), .I_IO_WDATA(I_IO_WDATA),
  .O_IO_RVALID(O_IO_RVALID), .O_PA_OUT(O_PA_OUT), .O_PA_OE(O_PA_OE), .O_PB_OE(O_PB_OE),
  .O_PB0_STRONG_PU(O_PB0_STRONG_PU), .O_PB0_PULLDOWN_EN(O_PB0_PULLDOWN_EN),
  .I_PC_PIN(I_PC_PIN), .O_PC_OE(O_PC_OE), .O_IRQ_A(O_IRQ_A));

// ### test/bip_ports_test.sv
// self-checking testbench of the bidirectional i/o port block
`timescale 1ns/1ns
module bip_ports_test;
  import bip_pkg::*;
  typedef struct packed {
    logic [3:0] a;
    logic       x;
    logic [3:0] d;
    logic [3:0] e;
    logic [3:0] q;
  } bip_row_type;
  // write, set pulls, read primary data back: addr, aux, data, pulls, expected
  localparam bip_row_type ROWS [9] = '{
    '{4'h2, 1'b1, 4'h0, 4'h0, 4'hf}, '{4'h2, 1'b0, 4'h5, 4'ha, 4'h5},
    '{4'h2, 1'b1, 4'hc, 4'ha, 4'h9}, '{4'h5, 1'b1, 4'h0, 4'h4, 4'h7},
    '{4'h5, 1'b1, 4'hf, 4'h4, 4'h7}, '{4'h5, 1'b0, 4'h6, 4'h8, 4'ha},
    '{4'h5, 1'b1, 4'hf, 4'h8, 4'h8}, '{4'h5, 1'b1, 4'h0, 4'h8, 4'h4},
    '{4'h3, 1'b0, 4'h5, 4'h8, 4'h0}};
  localparam logic [3:0] STEPS [6] = '{4'h1, 4'h0, 4'h8, 4'h4, 4'h6, 4'h4};
  logic       clk, rst_n, ce, aux, wr, rd, rvalid, pu, pd, irq_a, irq_b;
  logic [3:0] addr, wd, rdata, pb_out, pb_oe, pc_out, pc_oe;
  logic [1:0] pa_out, pa_oe;
  logic [9:0] pull, pin;
  int         errors, checks, na, nb;
  bip_ports u_dut (
    .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_IO_ADDR(addr), .I_IO_AUX(aux),
    .I_IO_WR(wr), .I_IO_RD(rd), .I_IO_WDATA(wd), .O_IO_RDATA(rdata), .O_IO_RVALID(rvalid),
    .I_PA_PIN(pin[9:8]), .O_PA_OUT(pa_out), .O_PA_OE(pa_oe), .I_PB_PIN(pin[7:4]),
    .O_PB_OUT(pb_out), .O_PB_OE(pb_oe), .O_PB0_STRONG_PU(pu), .O_PB0_PULLDOWN_EN(pd),
    .I_PC_PIN(pin[3:0]), .O_PC_OUT(pc_out), .O_PC_OE(pc_oe), .O_IRQ_A(irq_a),
    .O_IRQ_B(irq_b));
  bip_pin_model u_pins (.i_out({pa_out, pb_out, pc_out}), .i_oe({pa_oe, pb_oe, pc_oe}),
    .i_pull(pull), .i_pb0_pu(pu), .o_pin(pin));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    na += irq_a;
    nb += irq_b;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic io(input logic w, input logic [3:0] a, input logic x, input logic [3:0] d);
    @(negedge clk);
    {wr, rd, addr, aux, wd} = {w, ~w, a, x, d};
    @(negedge clk);
    {wr, rd} = 2'b00;
  endtask
  task automatic rst_chk;
    chk({pu, pd, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe, rvalid, irq_a, irq_b},
      {2'b10, PA_LATCH_RST, 2'h0, PB_DATA_RST, 4'h0, PC_DATA_RST, 4'h0, 3'h0});
    chk(pin[4], 1'b1);
  endtask
  task automatic conclude;
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    {rst_n, ce, aux, wr, rd} = 5'b01000;
    {addr, wd} = 8'h00;
    pull = 10'h000;
    repeat (4) @(negedge clk);
    rst_chk();
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    chk({pu, pd}, 2'b01);
    foreach (ROWS[i]) begin
      io(1'b1, ROWS[i].a, ROWS[i].x, ROWS[i].d);
      pull = {ROWS[i].e[3], ROWS[i].e[0], ROWS[i].e, ROWS[i].e};
      repeat (3) @(negedge clk);
      io(1'b0, ROWS[i].a, 1'b0, 4'h0);
      chk({rvalid, rdata}, {1'b1, ROWS[i].q});
    end
    pull[9:8] = 2'b00;
    repeat (3) @(negedge clk);
    io(1'b0, ADDR_PORT_A, 1'b0, 4'h0);
    chk({pa_oe, rdata & 4'h9}, 6'h00);
    io(1'b1, ADDR_PORT_A, 1'b0, 4'h8);
    chk({pa_oe, pa_out, pin[9:8]}, 6'h3a);
    // first nibble after turning to input may still show the driven level
    io(1'b0, ADDR_PORT_A, 1'b0, 4'h0);
    chk(pa_oe, 2'b00);
    repeat (2) @(negedge clk);
    io(1'b0, ADDR_PORT_A, 1'b0, 4'h0);
    chk(rdata & 4'h9, 4'h0);
    pull[9:8] = 2'b11;
    io(1'b1, ADDR_PORT_A, 1'b0, 4'h9);
    io(1'b0, ADDR_PORT_A, 1'b0, 4'h0);
    chk(rdata & 4'h9, 4'h9);
    ce = 1'b0;
    io(1'b1, ADDR_PORT_B, 1'b0, 4'h0);
    ce = 1'b1;
    chk(pb_out, 4'h5);
    pull[3:0] = 4'h0;
    io(1'b1, ADDR_PORT_C, 1'b1, 4'h9);
    io(1'b1, ADDR_PORT_C, 1'b1, 4'h7);
    foreach (STEPS[i]) begin
      pull[3:0] = STEPS[i];
      repeat (8) @(negedge clk);
    end
    chk({na[3:0], nb[3:0]}, 8'h21);
    // reset with the control byte half written
    io(1'b1, ADDR_PORT_C, 1'b1, 4'hf);
    rst_n = 1'b0;
    @(negedge clk);
    rst_chk();
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    io(1'b1, ADDR_PORT_C, 1'b1, 4'h0);
    chk(pc_oe, 4'h3);
    conclude();
  end
endmodule // bip_ports_test
